// >>> logic/vpd_acquisition.sv
`timescale 1ns/10ps
// Contract
// - Three modes: packet 8/30 lines, VPS line 16, teletext header bytes.
// - PDC mode takes only 8/30 lines; format 1 bytes stored unaltered.
// - Format 2 protected bytes are Hamming checked, single errors corrected.
// - Header mode order 1X stores all header bytes 4-45, protected ones corrected.
// - Stored bytes readable over I2C at any time.
// - Power-on state is VPS mode.
// - Data RAM is writable over I2C and reads back what was written.
// - Data set valid rises when a reception completes.
// - Stop after read of 4..40 clears data set valid unless new data came.
// - VPS mode: valid pin low after reception, high at line 16 start.
// - PDC/header: valid pin low on valid line, restored at next field.
// - Stop after read of 4..40 loads 255 into 4..40 unless new data.
// - New reception overwrites the all-ones contents.
// - Bit 0 in PDC mode: 0 format 2, 1 format 1 or header.
// - Bit 1: 0 VPS mode, 1 PDC mode.
// - Bit 2: 0 format 1 storage, 1 header mode.
// - Order bits: 00 38-45,30-37; 01 22-29,14-21; 1X linear 4-45.
// - Data set valid bit 5 is read only.
// - First received bit is stored in bit 7.
// - Format 2 packs two decoded nibbles into one register.
module vpd_acquisition (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// I2C pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	// Slicer and acquisition timing
	input wire logic rxBit,
	input wire logic rxBitStrobe,
	input wire logic rxLineStart,
	input wire logic [1:0] rxLineKind,
	input wire logic rxLineDone,
	input wire logic line16Start,
	input wire logic fieldStart,
	// Data valid pin
	output logic dataValidN
);
	// ************************************************
	// Declarations
	// ************************************************
	logic [7:0] ctrlReg;
	logic [7:0] dataMem [0:vpd_pkg::DATA_REGS-1];
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic sclD;
	logic sdaD;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	vpd_pkg::vpd_state_e stateReg;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] txShift;
	logic [7:0] subAddr;
	logic firstByte;
	logic readDir;
	logic busy;
	logic readTouched;
	logic newDuring;
	logic i2cWr;
	logic fillEvt;
	logic newData;
	logic [1:0] wantKind;
	logic lineActive;
	logic [1:0] curKind;
	logic [6:0] rxShift;
	logic [2:0] rxBitCnt;
	logic [5:0] rxIdx;
	logic [7:0] rxByte;
	logic byteDone;
	logic [3:0] pendNib;
	logic stEn;
	logic pendLd;
	logic [5:0] stAddr;
	logic [7:0] stVal;
	logic [3:0] nib;
	logic drvLow;
	vpd_ham_if ham ();

	vpd_hamming_dec uHam (
		.h(ham.dec)
	);

	function automatic logic [7:0] readByte(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == vpd_pkg::REG_CTRL) begin
			r = {2'h0, ctrlReg[5:0]};
		end else if (a >= vpd_pkg::REG_DATA_FIRST && a <= vpd_pkg::REG_DATA_LAST) begin
			r = dataMem[6'(a - vpd_pkg::REG_DATA_FIRST)];
		end
		return r;
	endfunction

	// ************************************************
	// Pin synchronisers and bus conditions
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			sclD <= sclSync[1];
			sdaD <= sdaSync[1];
		end
	end

	assign sclRise = sclSync[1] && !sclD;
	assign sclFall = !sclSync[1] && sclD;
	assign startCond = sclSync[1] && sclD && sdaD && !sdaSync[1];
	assign stopCond = sclSync[1] && sclD && !sdaD && sdaSync[1];
	assign i2cWr = (stateReg == vpd_pkg::S_RECV) && sclFall && bitCnt == 4'h8 && !firstByte;
	assign newData = rxLineDone && lineActive;
	assign fillEvt = stopCond && readTouched && !newDuring && !newData;

	// ************************************************
	// I2C slave
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stateReg <= vpd_pkg::S_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			txShift <= 8'hff;
			subAddr <= 8'h00;
			firstByte <= 1'b0;
			readDir <= 1'b0;
		end else if (startCond) begin
			stateReg <= vpd_pkg::S_ADDR;
			bitCnt <= 4'h0;
		end else if (stopCond) begin
			stateReg <= vpd_pkg::S_IDLE;
		end else if (sclRise) begin
			shiftIn <= {shiftIn[6:0], sdaSync[1]};
			bitCnt <= 4'(bitCnt + 4'h1);
			if (stateReg == vpd_pkg::S_SEND_ACK && sdaSync[1]) begin
				stateReg <= vpd_pkg::S_IDLE;
			end
		end else if (sclFall) begin
			case (stateReg)
				vpd_pkg::S_ADDR: begin
					if (bitCnt == 4'h8) begin
						if (shiftIn[7:1] == vpd_pkg::I2C_DEV_ADDR) begin
							stateReg <= vpd_pkg::S_ADDR_ACK;
							readDir <= shiftIn[0];
						end else begin
							stateReg <= vpd_pkg::S_IDLE;
						end
					end
				end
				vpd_pkg::S_ADDR_ACK: begin
					bitCnt <= 4'h0;
					firstByte <= !readDir;
					if (readDir) begin
						stateReg <= vpd_pkg::S_SEND;
						txShift <= readByte(subAddr);
						subAddr <= 8'(subAddr + 8'h01);
					end else begin
						stateReg <= vpd_pkg::S_RECV;
					end
				end
				vpd_pkg::S_RECV: begin
					if (bitCnt == 4'h8) begin
						stateReg <= vpd_pkg::S_RECV_ACK;
						firstByte <= 1'b0;
						subAddr <= firstByte ? shiftIn : 8'(subAddr + 8'h01);
					end
				end
				vpd_pkg::S_RECV_ACK: begin
					stateReg <= vpd_pkg::S_RECV;
					bitCnt <= 4'h0;
				end
				vpd_pkg::S_SEND: begin
					if (bitCnt == 4'h8) begin
						stateReg <= vpd_pkg::S_SEND_ACK;
						txShift <= 8'hff;
					end else begin
						txShift <= {txShift[6:0], 1'b1};
					end
				end
				vpd_pkg::S_SEND_ACK: begin
					stateReg <= vpd_pkg::S_SEND;
					bitCnt <= 4'h0;
					txShift <= readByte(subAddr);
					subAddr <= 8'(subAddr + 8'h01);
				end
				default: begin
					stateReg <= vpd_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Open-drain SDA, enable low while pulling low
	assign drvLow = stateReg == vpd_pkg::S_ADDR_ACK || stateReg == vpd_pkg::S_RECV_ACK
		|| (stateReg == vpd_pkg::S_SEND && !txShift[7]);
	assign sdaOut = 1'b0;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sdaOeN <= 1'b1;
		end else begin
			sdaOeN <= !drvLow;
		end
	end

	// ************************************************
	// Read tracking for flag clear and fill
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			readTouched <= 1'b0;
			newDuring <= 1'b0;
		end else if (stopCond) begin
			busy <= 1'b0;
			readTouched <= 1'b0;
			newDuring <= 1'b0;
		end else begin
			if (startCond) begin
				busy <= 1'b1;
			end
			if (newData && busy) begin
				newDuring <= 1'b1;
			end
			if (sclFall && readDir && (stateReg == vpd_pkg::S_ADDR_ACK || stateReg == vpd_pkg::S_SEND_ACK)
				&& subAddr >= vpd_pkg::REG_DATA_FIRST && subAddr <= vpd_pkg::REG_DATA_LAST) begin
				readTouched <= 1'b1;
			end
		end
	end

	// ************************************************
	// Control register
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrlReg <= vpd_pkg::CTRL_RESET;
		end else begin
			if (i2cWr && subAddr == vpd_pkg::REG_CTRL) begin
				ctrlReg[4:0] <= shiftIn[4:0] & vpd_pkg::CTRL_WR_MASK;
			end
			if (newData) begin
				ctrlReg[vpd_pkg::BIT_DSV] <= 1'b1;
			end else if (fillEvt) begin
				ctrlReg[vpd_pkg::BIT_DSV] <= 1'b0;
			end
		end
	end

	// ************************************************
	// Line selection and bit assembly
	// ************************************************
	always_comb begin
		if (!ctrlReg[vpd_pkg::BIT_SRC]) begin
			wantKind = vpd_pkg::KIND_VPS;
		end else if (!ctrlReg[vpd_pkg::BIT_FMT]) begin
			wantKind = vpd_pkg::KIND_F2;
		end else if (ctrlReg[vpd_pkg::BIT_HDR]) begin
			wantKind = vpd_pkg::KIND_HDR;
		end else begin
			wantKind = vpd_pkg::KIND_F1;
		end
	end

	assign rxByte = {rxShift, rxBit};
	assign byteDone = rxBitStrobe && lineActive && rxBitCnt == 3'h7;
	assign ham.code = rxByte;
	assign nib = ham.data;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lineActive <= 1'b0;
			curKind <= vpd_pkg::KIND_VPS;
			rxShift <= 7'h00;
			rxBitCnt <= 3'h0;
			rxIdx <= 6'h01;
			pendNib <= 4'h0;
		end else if (rxLineStart) begin
			lineActive <= rxLineKind == wantKind;
			curKind <= rxLineKind;
			rxBitCnt <= 3'h0;
			rxIdx <= 6'h01;
		end else if (rxLineDone) begin
			lineActive <= 1'b0;
		end else if (rxBitStrobe && lineActive) begin
			rxShift <= rxByte[6:0];
			rxBitCnt <= 3'(rxBitCnt + 3'h1);
			if (byteDone) begin
				rxIdx <= 6'(rxIdx + 6'h01);
				if (pendLd) begin
					pendNib <= nib;
				end
			end
		end
	end

	// ************************************************
	// Byte placement per mode
	// ************************************************
	always_comb begin
		stEn = 1'b0;
		pendLd = 1'b0;
		stAddr = 6'h00;
		stVal = rxByte;
		case (curKind)
			vpd_pkg::KIND_VPS: begin
				stEn = 1'b1;
				case (rxIdx)
					6'h0b: stAddr = 6'h04;
					6'h0c: stAddr = 6'h05;
					6'h0d: stAddr = 6'h06;
					6'h0e: stAddr = 6'h07;
					6'h05: stAddr = 6'h08;
					6'h0f: stAddr = 6'h09;
					default: stEn = 1'b0;
				endcase
			end
			vpd_pkg::KIND_F1: begin
				stEn = rxIdx >= 6'h0d && rxIdx <= 6'h2d;
				if (rxIdx == 6'h0d || rxIdx == 6'h0e) begin
					stAddr = 6'(rxIdx - 6'h02);
				end else if (rxIdx <= 6'h15) begin
					stAddr = 6'(rxIdx - 6'h0b);
				end else begin
					stAddr = 6'(rxIdx - 6'h09);
				end
			end
			vpd_pkg::KIND_F2: begin
				if (rxIdx >= 6'h1a && rxIdx <= 6'h2d) begin
					stEn = 1'b1;
					stAddr = 6'(rxIdx - 6'h09);
				end else if (rxIdx == 6'h0d) begin
					stEn = 1'b1;
					stAddr = 6'h0a;
					stVal = {nib, 4'h0};
				end else if (rxIdx >= 6'h0e && rxIdx <= 6'h19) begin
					pendLd = !rxIdx[0];
					stEn = rxIdx[0];
					stVal = {pendNib, nib};
					if (rxIdx == 6'h0f) begin
						stAddr = 6'h08;
					end else if (rxIdx == 6'h19) begin
						stAddr = 6'h09;
					end else begin
						stAddr = 6'(6'h04 + ((rxIdx - 6'h11) >> 1));
					end
				end
			end
			default: begin
				if (ctrlReg[vpd_pkg::BIT_ORD_HI]) begin
					if (rxIdx >= 6'h04 && rxIdx <= 6'h0d) begin
						pendLd = !rxIdx[0];
						stEn = rxIdx[0];
						stVal = {pendNib, nib};
						stAddr = 6'(6'h04 + ((rxIdx - 6'h05) >> 1));
					end else if (rxIdx >= 6'h0e && rxIdx <= 6'h2d) begin
						stEn = 1'b1;
						stAddr = 6'(rxIdx - 6'h05);
					end
				end else if (!ctrlReg[vpd_pkg::BIT_ORD_LO]) begin
					stEn = rxIdx >= 6'h1e && rxIdx <= 6'h2d;
					stAddr = rxIdx >= 6'h26 ? 6'(rxIdx - 6'h22) : 6'(rxIdx - 6'h12);
				end else begin
					stEn = rxIdx >= 6'h0e && rxIdx <= 6'h1d;
					stAddr = rxIdx >= 6'h16 ? 6'(rxIdx - 6'h12) : 6'(rxIdx - 6'h02);
				end
			end
		endcase
	end

	// ************************************************
	// Data registers
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < vpd_pkg::DATA_REGS; i++) begin
				dataMem[i] <= vpd_pkg::DATA_RESET;
			end
		end else begin
			if (fillEvt) begin
				for (int i = 0; i < vpd_pkg::DATA_REGS; i++) begin
					dataMem[i] <= vpd_pkg::DATA_FILL;
				end
			end
			if (i2cWr && subAddr >= vpd_pkg::REG_DATA_FIRST && subAddr <= vpd_pkg::REG_DATA_LAST) begin
				dataMem[6'(subAddr - vpd_pkg::REG_DATA_FIRST)] <= shiftIn;
			end
			if (byteDone && stEn) begin
				dataMem[6'(stAddr - 6'h04)] <= stVal;
			end
		end
	end

	// ************************************************
	// Data valid pin
	// ************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dataValidN <= 1'b1;
		end else if (newData) begin
			dataValidN <= 1'b0;
		end else if (!ctrlReg[vpd_pkg::BIT_SRC] && line16Start) begin
			dataValidN <= 1'b1;
		end else if (ctrlReg[vpd_pkg::BIT_SRC] && fieldStart) begin
			dataValidN <= 1'b1;
		end
	end
endmodule // vpd_acquisition

// >>> logic/vpd_pkg.sv
package vpd_pkg;
	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] REG_CTRL = 8'h03;
	localparam logic [7:0] REG_DATA_FIRST = 8'h04;
	localparam logic [7:0] REG_DATA_LAST = 8'h28;
	localparam int DATA_REGS = 37;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DATA_FILL = 8'hff;
	// Control fields
	localparam int BIT_FMT = 0;
	localparam int BIT_SRC = 1;
	localparam int BIT_HDR = 2;
	localparam int BIT_ORD_LO = 3;
	localparam int BIT_ORD_HI = 4;
	localparam int BIT_DSV = 5;
	localparam logic [4:0] CTRL_WR_MASK = 5'h1f;

	// ************************************************
	// I2C slave address (arbitrary)
	// ************************************************
	localparam logic [6:0] I2C_DEV_ADDR = 7'h2e;

	// ************************************************
	// Line kinds from the slicer timing
	// ************************************************
	localparam logic [1:0] KIND_VPS = 2'h0;
	localparam logic [1:0] KIND_F1 = 2'h1;
	localparam logic [1:0] KIND_F2 = 2'h2;
	localparam logic [1:0] KIND_HDR = 2'h3;

	// ************************************************
	// I2C slave states
	// ************************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_ADDR_ACK = 3'h3,
		S_RECV = 3'h2,
		S_RECV_ACK = 3'h6,
		S_SEND = 3'h7,
		S_SEND_ACK = 3'h5
	} vpd_state_e;
endpackage

// >>> logic/vpd_ham_if.sv
`timescale 1ns/10ps
interface vpd_ham_if;
	logic [7:0] code;
	logic [3:0] data;
	modport dec (input code, output data);
	modport user (output code, input data);
endinterface

// >>> logic/vpd_hamming_dec.sv
`timescale 1ns/10ps
module vpd_hamming_dec (
	// Code byte in, nibble out
	vpd_ham_if.dec h
);
	// ************************************************
	// Parity tests, first bit received in bit 7
	// ************************************************
	logic testA;
	logic testB;
	logic testC;
	logic testAll;
	assign testA = h.code[7] ^ h.code[6] ^ h.code[2] ^ h.code[0];
	assign testB = h.code[6] ^ h.code[5] ^ h.code[4] ^ h.code[0];
	assign testC = h.code[6] ^ h.code[4] ^ h.code[3] ^ h.code[2];
	assign testAll = ^h.code;

	// ************************************************
	// Single error correction of data bits
	// ************************************************
	always_comb begin
		h.data = {h.code[6], h.code[4], h.code[2], h.code[0]};
		if (!testAll) begin
			if (!testA && !testB && !testC) begin
				h.data[3] = ~h.code[6];
			end else if (testA && !testB && !testC) begin
				h.data[2] = ~h.code[4];
			end else if (!testA && testB && !testC) begin
				h.data[1] = ~h.code[2];
			end else if (!testA && !testB && testC) begin
				h.data[0] = ~h.code[0];
			end
		end
	end
endmodule // vpd_hamming_dec

// >>> verification/vpd_i2c_host.sv
`timescale 1ns/10ps
module vpd_i2c_host (
	// Clock
	input wire logic mclk,
	// Bus lines
	input wire logic sdaIn,
	output logic scl,
	output logic sdaDrv
);
	// ****
	// Bit timing, SCL low and high 8 cycles each
	// ****
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic q();
		repeat (4) @(negedge mclk);
	endtask
	task automatic start();
		q();
		sdaDrv = 1'b1;
		q();
		scl = 1'b1;
		q();
		sdaDrv = 1'b0;
		q();
		scl = 1'b0;
	endtask
	task automatic stop();
		q();
		sdaDrv = 1'b0;
		q();
		scl = 1'b1;
		q();
		sdaDrv = 1'b1;
		q();
	endtask
	task automatic bitx(input logic b, output logic r);
		q();
		sdaDrv = b;
		q();
		scl = 1'b1;
		q();
		q();
		r = sdaIn;
		scl = 1'b0;
	endtask
	// Byte out or in, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(ackIn, ack);
	endtask
endmodule // vpd_i2c_host

// >>> verification/vpd_acquisition_checker.sv
`timescale 1ns/10ps
module vpd_acquisition_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Bus pins
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	// Timing and valid pin
	input wire logic rxLineDone,
	input wire logic line16Start,
	input wire logic fieldStart,
	input wire logic dataValidN
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	dvn_fall_cause_a: assert property ($fell(dataValidN) |-> $past(rxLineDone))
		else $error("valid pin fell without a line end");
	dvn_rise_cause_a: assert property ($rose(dataValidN) |-> $past(line16Start) || $past(fieldStart))
		else $error("valid pin rose without line or field start");
	dvn_restore_a: assert property (line16Start && fieldStart && !rxLineDone |=> dataValidN)
		else $error("valid pin not restored");
	dvn_hold_a: assert property (!rxLineDone && !line16Start && !fieldStart |=> $stable(dataValidN))
		else $error("valid pin moved without cause");
	sda_scl_high_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOeN))
		else $error("data line moved while clock high");
	sda_low_stands_a: assert property ($fell(sdaOeN) |-> !sdaOeN [*8])
		else $error("driven bit too short");
	sda_change_low_a: assert property ($changed(sdaOeN) |-> !sclIn && !$past(sclIn, 2))
		else $error("data line changed outside clock low");
	sda_open_drain_a: assert property (!sdaOeN |-> sdaOut == 1'b0)
		else $error("data line driven high");
	cover property ($fell(dataValidN));
	cover property ($rose(dataValidN));
	cover property ($fell(sdaOeN));
endmodule // vpd_acquisition_checker

bind vpd_acquisition vpd_acquisition_checker chk (.mclk(mclk), .nrst(nrst), .sclIn(sclIn), .sdaOut(sdaOut),
	.sdaOeN(sdaOeN), .rxLineDone(rxLineDone), .line16Start(line16Start), .fieldStart(fieldStart),
	.dataValidN(dataValidN));

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic mclk = 1'b0, nrst = 1'b0, rxBit = 1'b0, rxBitStrobe = 1'b0, rxLineStart = 1'b0, rxLineDone = 1'b0;
	logic line16Start = 1'b0, fieldStart = 1'b0;
	logic [1:0] rxLineKind = 2'h0;
	logic scl, sdaDrv, sdaOut, sdaOeN, dataValidN;
	wire sdaIn = sdaDrv & sdaOeN;
	int failures = 0, checked = 0, cyc = 0;
	logic [31:0] seed = 32'h582bd546;
	logic [7:0] mdl[4:40], ctrl = 8'h00, b[1:45], rd[$], d[$];
	localparam logic [7:0] MC[6] = '{8'h00, 8'h03, 8'h02, 8'h07, 8'h0f, 8'h17};
	localparam logic [1:0] MK[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
	localparam int VI[6] = '{11, 12, 13, 14, 5, 15};
	localparam int FI[6] = '{16, 18, 20, 22, 14, 24};
	always #10 mclk = ~mclk;
	vpd_acquisition dut (.mclk(mclk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.rxBit(rxBit), .rxBitStrobe(rxBitStrobe), .rxLineStart(rxLineStart), .rxLineKind(rxLineKind),
		.rxLineDone(rxLineDone), .line16Start(line16Start), .fieldStart(fieldStart), .dataValidN(dataValidN));
	vpd_i2c_host mst (.mclk(mclk), .sdaIn(sdaIn), .scl(scl), .sdaDrv(sdaDrv));
	// ****
	// Helpers
	// ****
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] ham(input logic [3:0] n, input int e);
		logic [7:0] c;
		c = {~(n[3] ^ n[1] ^ n[0]), n[3], ~(n[3] ^ n[2] ^ n[0]), n[2], ~(n[3] ^ n[2] ^ n[1]), n[1], 1'b0, n[0]};
		c[1] = ~^c;
		return c ^ (8'h01 << e);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic i2cWr(input logic [7:0] sub, input logic [7:0] v[$]);
		logic [7:0] r;
		logic a;
		mst.start();
		mst.xfer({vpd_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, r, a);
		chk(8'(a), 8'h00);
		mst.xfer(sub, 1'b1, r, a);
		foreach (v[i])
			mst.xfer(v[i], 1'b1, r, a);
		mst.stop();
	endtask
	task automatic i2cRd(input logic [7:0] sub, input int n);
		logic [7:0] r;
		logic a;
		rd = {};
		mst.start();
		mst.xfer({vpd_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, r, a);
		mst.xfer(sub, 1'b1, r, a);
		mst.start();
		mst.xfer({vpd_pkg::I2C_DEV_ADDR, 1'b1}, 1'b1, r, a);
		chk(8'(a), 8'h00);
		for (int i = 1; i <= n; i++) begin
			mst.xfer(8'hff, i == n, r, a);
			rd.push_back(r);
		end
		mst.stop();
	endtask
	task automatic rdCtrl();
		i2cRd(vpd_pkg::REG_CTRL, 1);
		chk(rd[0], ctrl);
	endtask
	task automatic rdAll();
		i2cRd(vpd_pkg::REG_DATA_FIRST, vpd_pkg::DATA_REGS);
		for (int i = 4; i <= 40; i++) begin
			chk(rd[i-4], mdl[i]);
			mdl[i] = vpd_pkg::DATA_FILL;
		end
		ctrl[5] = 1'b0;
	endtask
	task automatic pulse(input logic l16, input logic fs);
		@(negedge mclk);
		line16Start = l16;
		fieldStart = fs;
		@(negedge mclk);
		line16Start = 1'b0;
		fieldStart = 1'b0;
		@(negedge mclk);
	endtask
	task automatic sendLine(input logic [1:0] kind, input bit acc);
		logic [3:0] nb[1:45];
		@(negedge mclk);
		rxLineKind = kind;
		rxLineStart = 1'b1;
		@(negedge mclk);
		rxLineStart = 1'b0;
		for (int i = 1; i <= 45; i++) begin
			nb[i] = 4'(rnd());
			b[i] = ((kind == 2'h2 && i >= 13 && i <= 25) || (kind == 2'h3 && i <= 13)) ? ham(nb[i], rnd() % 8) : rnd();
			for (int k = 7; k >= 0; k--) begin
				rxBit = b[i][k];
				rxBitStrobe = 1'b1;
				@(negedge mclk);
			end
		end
		rxBitStrobe = 1'b0;
		rxLineDone = 1'b1;
		@(negedge mclk);
		rxLineDone = 1'b0;
		chk(8'(dataValidN), 8'(!acc));
		if (acc) begin
			ctrl[5] = 1'b1;
			for (int i = 4; i <= 40; i++)
				case (kind)
					2'h0: mdl[i] = (i <= 9) ? b[VI[i-4]] : mdl[i];
					2'h1: mdl[i] = (i > 36) ? mdl[i] : (i <= 10) ? b[i+11] : (i <= 12) ? b[i+2] : b[i+9];
					2'h2: mdl[i] = (i <= 9) ? {nb[FI[i-4]], nb[FI[i-4]+1]} : (i == 10) ? {nb[13], 4'h0} :
						(i >= 17 && i <= 36) ? b[i+9] : mdl[i];
					default: mdl[i] = ctrl[4] ? ((i <= 8) ? {nb[2*i-4], nb[2*i-3]} : b[i+5]) :
						(i > 19) ? mdl[i] : b[i + (i <= 11 ? 16 : 0) + (ctrl[3] ? 2 : 18)];
				endcase
		end
	endtask
	// ****
	// Sequence
	// ****
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		for (int i = 4; i <= 40; i++)
			mdl[i] = vpd_pkg::DATA_RESET;
		repeat (5) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		rdCtrl();
		i2cWr(vpd_pkg::REG_CTRL, {8'hff});
		ctrl = 8'h1f;
		rdCtrl();
		d = {rnd(), rnd(), rnd(), rnd()};
		for (int i = 0; i < 4; i++)
			mdl[i+4] = d[i];
		i2cWr(vpd_pkg::REG_DATA_FIRST, d);
		rdAll();
		$display("setup test done");
		for (int m = 0; m < 6; m++) begin
			ctrl = MC[m];
			i2cWr(vpd_pkg::REG_CTRL, {ctrl});
			pulse(1'b1, 1'b1);
			chk(8'(dataValidN), 8'h01);
			sendLine(MK[m] ^ 2'h1, 1'b0);
			sendLine(MK[m], 1'b1);
			rdCtrl();
			rdAll();
			rdCtrl();
			pulse(1'b1, 1'b0);
			chk(8'(dataValidN), 8'(MK[m] == 2'h0));
			$display("mode %h test done", MC[m]);
		end
		finish_test();
	end
endmodule // tb_top
